//--- design/pcg_pkg.sv
package pcg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NUM_PERIPH = 48;

  // register offsets
  localparam logic [3:0] OFF_CTRL_A  = 4'h0;
  localparam logic [3:0] OFF_CTRL_B  = 4'h1;
  localparam logic [3:0] OFF_CTRL_C  = 4'h2;
  localparam logic [3:0] OFF_ENABLED = 4'h3;

  // writable bits of each register
  localparam logic [15:0] MASK_CTRL_A = 16'hf9ff;
  localparam logic [15:0] MASK_CTRL_B = 16'hffff;
  localparam logic [15:0] MASK_CTRL_C = 16'hf003;

  localparam logic [15:0] RESET_CTRL_A = 16'h0000;
  localparam logic [15:0] RESET_CTRL_B = 16'h0000;
  localparam logic [15:0] RESET_CTRL_C = 16'h0000;
  localparam logic [15:0] READ_ZERO    = 16'h0000;

  // field positions in ctrl_a
  localparam int BIT_TIMER_FIVE  = 15;
  localparam int BIT_TIMER_ONE   = 11;
  localparam int BIT_CODEC_IF    = 8;
  localparam int BIT_I2C_A       = 7;
  localparam int BIT_ADC_A       = 0;
  // ctrl_b
  localparam int BIT_CAPTURE_CH8 = 15;
  localparam int BIT_COMPARE_CH8 = 7;
  // ctrl_c
  localparam int BIT_TIMER_NINE  = 15;
  localparam int BIT_I2C_B       = 1;
  localparam int BIT_ADC_B       = 0;

  // gate vector bits: [15:0]=ctrl_a, [31:16]=ctrl_b, [47:32]=ctrl_c
  localparam int GATE_B_BASE = 16;
  localparam int GATE_C_BASE = 32;
endpackage

//--- design/pcg_clock_gate.sv
// glitch-free gate: enable latched while clock is low
module pcg_clock_gate (
  // clock
  input  wire logic clk,
  // control
  input  wire logic enable,
  // gated clock
  output logic      gated_clk
);
  logic en_latch;

  always_latch
  begin
    if (!clk)
    begin
      en_latch <= enable;
    end
  end

  assign gated_clk = clk & en_latch;
endmodule

//--- design/pcg_top.sv
// What this block does
// - disabled peripheral loses all its clocks
// - disabled peripheral registers ignore writes, read undefined
// - enabled only if bit clear and present
// - present peripherals enabled after reset
// - set bit stops module one cycle later
// - cleared bit restarts module one cycle later
// - one disables, zero enables, every present bit
// - ctrl_a maps timers, codec, i2c, uart, spi, can, adc
// - ctrl_b maps capture and compare channels
// - ctrl_c maps timers six-nine, i2c_b, adc_b
module pcg_top #(
  parameter logic [47:0] PRESENT = 48'hf003_ffff_f9ff
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // per-peripheral status and clocks
  output logic [47:0]      periph_enable,
  output logic [47:0]      periph_reg_block,
  output logic [47:0]      periph_clk
);
  logic [15:0] peripheral_disable_ctrl_a;
  logic [15:0] peripheral_disable_ctrl_b;
  logic [15:0] peripheral_disable_ctrl_c;
  logic [15:0] next_ctrl_a;
  logic [15:0] next_ctrl_b;
  logic [15:0] next_ctrl_c;
  logic [15:0] next_rdata;
  logic [47:0] disable_vec;
  logic [47:0] next_enable;
  logic [47:0] next_reg_block;

  assign disable_vec = {peripheral_disable_ctrl_c,
                        peripheral_disable_ctrl_b,
                        peripheral_disable_ctrl_a};

  // register writes
  always_comb
  begin
    next_ctrl_a = peripheral_disable_ctrl_a;
    next_ctrl_b = peripheral_disable_ctrl_b;
    next_ctrl_c = peripheral_disable_ctrl_c;
    if (reg_write)
    begin
      case (reg_addr)
        pcg_pkg::OFF_CTRL_A:
          next_ctrl_a = reg_wdata & pcg_pkg::MASK_CTRL_A;
        pcg_pkg::OFF_CTRL_B:
          next_ctrl_b = reg_wdata & pcg_pkg::MASK_CTRL_B;
        pcg_pkg::OFF_CTRL_C:
          next_ctrl_c = reg_wdata & pcg_pkg::MASK_CTRL_C;
        default:
          next_ctrl_a = peripheral_disable_ctrl_a;
      endcase
    end
  end

  // read data one cycle later; unmapped reads zero
  always_comb
  begin
    next_rdata = pcg_pkg::READ_ZERO;
    if (reg_read)
    begin
      case (reg_addr)
        pcg_pkg::OFF_CTRL_A:  next_rdata = peripheral_disable_ctrl_a;
        pcg_pkg::OFF_CTRL_B:  next_rdata = peripheral_disable_ctrl_b;
        pcg_pkg::OFF_CTRL_C:  next_rdata = peripheral_disable_ctrl_c;
        pcg_pkg::OFF_ENABLED: next_rdata = periph_enable[15:0];
        default:              next_rdata = pcg_pkg::READ_ZERO;
      endcase
    end
  end

  // one means off; present and clear means on
  always_comb
  begin
    next_enable = ~disable_vec & PRESENT;
    next_reg_block = ~next_enable;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      peripheral_disable_ctrl_a <= pcg_pkg::RESET_CTRL_A;
      peripheral_disable_ctrl_b <= pcg_pkg::RESET_CTRL_B;
      peripheral_disable_ctrl_c <= pcg_pkg::RESET_CTRL_C;
      reg_rdata                 <= pcg_pkg::READ_ZERO;
      periph_enable             <= '0;
      periph_reg_block          <= '1;
    end
    else
    begin
      peripheral_disable_ctrl_a <= next_ctrl_a;
      peripheral_disable_ctrl_b <= next_ctrl_b;
      peripheral_disable_ctrl_c <= next_ctrl_c;
      reg_rdata                 <= next_rdata;
      // one cycle from register change to module effect
      periph_enable             <= next_enable;
      periph_reg_block          <= next_reg_block;
    end
  end

  genvar g;
  generate
    for (g = 0; g < pcg_pkg::NUM_PERIPH; g++)
    begin : gates
      pcg_clock_gate u_gate (
        .clk       (clk),
        .enable    (periph_enable[g]),
        .gated_clk (periph_clk[g])
      );
    end
  endgenerate

  // assertions
  stop_one_cycle_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_write && reg_addr == pcg_pkg::OFF_CTRL_A
     && reg_wdata[pcg_pkg::BIT_ADC_A])
    |=> ##1 !periph_enable[pcg_pkg::BIT_ADC_A])
    else $error("module not stopped one cycle after disable");

  start_one_cycle_a: assert property (
    @(posedge clk) disable iff (rst)
    (reg_write && reg_addr == pcg_pkg::OFF_CTRL_B
     && !reg_wdata[pcg_pkg::BIT_COMPARE_CH8])
    |=> ##1 periph_enable[pcg_pkg::GATE_B_BASE + pcg_pkg::BIT_COMPARE_CH8]
            == PRESENT[pcg_pkg::GATE_B_BASE + pcg_pkg::BIT_COMPARE_CH8])
    else $error("module not restarted one cycle after enable");

  reg_block_a: assert property (
    @(posedge clk) disable iff (rst)
    periph_reg_block == ~periph_enable)
    else $error("register block does not follow disable");

  absent_off_a: assert property (
    @(posedge clk) disable iff (rst)
    (periph_enable & ~PRESENT) == '0)
    else $error("absent peripheral enabled");

  unimpl_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    (peripheral_disable_ctrl_a & ~pcg_pkg::MASK_CTRL_A) == '0
    && (peripheral_disable_ctrl_c & ~pcg_pkg::MASK_CTRL_C) == '0)
    else $error("unimplemented bit holds one");

  reset_enabled_a: assert property (
    @(posedge clk)
    $fell(rst) |=> periph_enable == PRESENT)
    else $error("present peripherals not enabled after reset");

  sequence write_c_s;
    reg_write && reg_addr == pcg_pkg::OFF_CTRL_C;
  endsequence

  polarity_c_a: assert property (
    @(posedge clk) disable iff (rst)
    write_c_s ##1 !reg_write ##1 !reg_write
    |-> periph_enable[pcg_pkg::GATE_C_BASE + pcg_pkg::BIT_I2C_B]
        == !$past(reg_wdata[pcg_pkg::BIT_I2C_B], 2))
    else $error("ctrl_c polarity or mapping wrong");

  read_back_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_read && reg_addr == pcg_pkg::OFF_CTRL_A
    |=> reg_rdata == $past(peripheral_disable_ctrl_a))
    else $error("ctrl_a read back wrong");

  gated_low_a: assert property (
    @(negedge clk) disable iff (rst)
    (!periph_enable[pcg_pkg::BIT_TIMER_ONE])
    |-> ##1 !periph_clk[pcg_pkg::BIT_TIMER_ONE])
    else $error("disabled clock still toggles");

  gated_runs_a: assert property (
    @(negedge clk) disable iff (rst)
    $past(periph_enable[pcg_pkg::BIT_TIMER_ONE])
    |-> periph_clk[pcg_pkg::BIT_TIMER_ONE])
    else $error("enabled clock missed a pulse");

  absent_quiet_a: assert property (
    @(negedge clk) disable iff (rst)
    (periph_clk & ~PRESENT) == '0)
    else $error("absent peripheral clocked");

  sequence no_reg_write_s;
    !reg_write || reg_addr > pcg_pkg::OFF_CTRL_C;
  endsequence

  regs_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    no_reg_write_s |=> $stable(peripheral_disable_ctrl_a)
                       && $stable(peripheral_disable_ctrl_b)
                       && $stable(peripheral_disable_ctrl_c))
    else $error("disable register changed without a write");

  write_a_lands_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_write && reg_addr == pcg_pkg::OFF_CTRL_A
    |=> peripheral_disable_ctrl_a
        == ($past(reg_wdata) & pcg_pkg::MASK_CTRL_A))
    else $error("ctrl_a write did not land");

  write_c_lands_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_write && reg_addr == pcg_pkg::OFF_CTRL_C
    |=> peripheral_disable_ctrl_c
        == ($past(reg_wdata) & pcg_pkg::MASK_CTRL_C))
    else $error("ctrl_c write did not land");

  reset_values_a: assert property (
    @(posedge clk)
    rst |=> peripheral_disable_ctrl_a == pcg_pkg::RESET_CTRL_A
            && peripheral_disable_ctrl_b == pcg_pkg::RESET_CTRL_B
            && peripheral_disable_ctrl_c == pcg_pkg::RESET_CTRL_C
            && periph_enable == '0 && periph_reg_block == '1)
    else $error("reset state wrong");

  rdata_idle_a: assert property (
    @(posedge clk) disable iff (rst)
    !reg_read |=> reg_rdata == pcg_pkg::READ_ZERO)
    else $error("read data not zero outside a read");

  read_back_b_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_read && reg_addr == pcg_pkg::OFF_CTRL_B
    |=> reg_rdata == $past(peripheral_disable_ctrl_b))
    else $error("ctrl_b read back wrong");

  read_back_c_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_read && reg_addr == pcg_pkg::OFF_CTRL_C
    |=> reg_rdata == $past(peripheral_disable_ctrl_c))
    else $error("ctrl_c read back wrong");

  read_status_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_read && reg_addr == pcg_pkg::OFF_ENABLED
    |=> reg_rdata == $past(periph_enable[pcg_pkg::DATA_W-1:0]))
    else $error("enable status read back wrong");

  read_unmapped_a: assert property (
    @(posedge clk) disable iff (rst)
    reg_read && reg_addr > pcg_pkg::OFF_ENABLED
    |=> reg_rdata == pcg_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  // a gate bit follows its disable bit one cycle later
  property gate_follows_p(int gate, logic off_bit);
    @(posedge clk) disable iff (rst)
    !$past(rst)
    |-> periph_enable[gate] == (!$past(off_bit) && PRESENT[gate]);
  endproperty

  timer_five_map_a: assert property (
    gate_follows_p(pcg_pkg::BIT_TIMER_FIVE,
                   peripheral_disable_ctrl_a[pcg_pkg::BIT_TIMER_FIVE]))
    else $error("timer five gate mapped wrong");

  timer_one_map_a: assert property (
    gate_follows_p(pcg_pkg::BIT_TIMER_ONE,
                   peripheral_disable_ctrl_a[pcg_pkg::BIT_TIMER_ONE]))
    else $error("timer one gate mapped wrong");

  codec_map_a: assert property (
    gate_follows_p(pcg_pkg::BIT_CODEC_IF,
                   peripheral_disable_ctrl_a[pcg_pkg::BIT_CODEC_IF]))
    else $error("codec gate mapped wrong");

  i2c_a_map_a: assert property (
    gate_follows_p(pcg_pkg::BIT_I2C_A,
                   peripheral_disable_ctrl_a[pcg_pkg::BIT_I2C_A]))
    else $error("first i2c gate mapped wrong");

  adc_a_map_a: assert property (
    gate_follows_p(pcg_pkg::BIT_ADC_A,
                   peripheral_disable_ctrl_a[pcg_pkg::BIT_ADC_A]))
    else $error("first adc gate mapped wrong");

  capture_map_a: assert property (
    gate_follows_p(pcg_pkg::GATE_B_BASE + pcg_pkg::BIT_CAPTURE_CH8,
                   peripheral_disable_ctrl_b[pcg_pkg::BIT_CAPTURE_CH8]))
    else $error("capture gate mapped wrong");

  compare_map_a: assert property (
    gate_follows_p(pcg_pkg::GATE_B_BASE + pcg_pkg::BIT_COMPARE_CH8,
                   peripheral_disable_ctrl_b[pcg_pkg::BIT_COMPARE_CH8]))
    else $error("compare gate mapped wrong");

  timer_nine_map_a: assert property (
    gate_follows_p(pcg_pkg::GATE_C_BASE + pcg_pkg::BIT_TIMER_NINE,
                   peripheral_disable_ctrl_c[pcg_pkg::BIT_TIMER_NINE]))
    else $error("timer nine gate mapped wrong");

  i2c_b_map_a: assert property (
    gate_follows_p(pcg_pkg::GATE_C_BASE + pcg_pkg::BIT_I2C_B,
                   peripheral_disable_ctrl_c[pcg_pkg::BIT_I2C_B]))
    else $error("second i2c gate mapped wrong");

  adc_b_map_a: assert property (
    gate_follows_p(pcg_pkg::GATE_C_BASE + pcg_pkg::BIT_ADC_B,
                   peripheral_disable_ctrl_c[pcg_pkg::BIT_ADC_B]))
    else $error("second adc gate mapped wrong");
endmodule

//--- dv/pcg_periph_model.sv
// far-side peripherals: each notes whether its gated clock ticked
module pcg_periph_model (
  // gated clocks
  input  wire logic [47:0] periph_clk,
  // bench control
  input  wire logic        clear,
  // activity seen since clear
  output logic      [47:0] ticked
);
  timeunit 1ns;
  timeprecision 1ps;
  for (genvar g = 0; g < 48; g++)
  begin : g_unit
    logic t;
    // a stopped peripheral never sees an edge
    always @(posedge periph_clk[g] or posedge clear)
      t <= clear ? 1'b0 : 1'b1;
    assign ticked[g] = t;
  end
endmodule

//--- dv/peripheral_clock_gate_control_test.sv
module peripheral_clock_gate_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // one absent peripheral in each register besides the unimplemented bits
  localparam logic [47:0] P = 48'hd003_bfff_f9fd;
  logic        clk = 0, rst = 1, reg_write = 0, reg_read = 0, clr = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [47:0] periph_enable, periph_reg_block, periph_clk, ticked;
  logic [47:0] exp_en = P;
  logic [15:0] regs [3] = '{16'h0000, 16'h0000, 16'h0000};
  int          error_cnt = 0, cmp_count = 0, seed = 21, tn = 0;
  always #2 clk = ~clk;
  pcg_top #(.PRESENT(P)) i_pcg_top (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .periph_enable(periph_enable), .periph_reg_block(periph_reg_block),
    .periph_clk(periph_clk));
  pcg_periph_model i_pcg_periph_model (.periph_clk(periph_clk),
    .clear(clr), .ticked(ticked));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    logic [15:0] m [3];
    m = '{pcg_pkg::MASK_CTRL_A, pcg_pkg::MASK_CTRL_B, pcg_pkg::MASK_CTRL_C};
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    if (a < 4'h3)
      regs[a[1:0]] = v & m[a[1:0]];
    #1 chk(periph_enable, exp_en);
    exp_en = ~{regs[2], regs[1], regs[0]} & P;
    @(posedge clk);
    #1 chk(periph_enable, exp_en);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic check_all;
    for (int a = 0; a < 3; a++)
    begin
      rd(4'(a));
      chk(48'(d), 48'(regs[a]));
    end
    rd(4'h3);
    chk(48'(d), 48'(exp_en[15:0]));
    rd(4'h9);
    chk(48'(d), 48'h0);
    chk(periph_reg_block, ~exp_en);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(ticked, exp_en);
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check_all;
    for (int a = 0; a < 3; a++)
      wr(4'(a), 16'hffff);
    check_all;
    // mid-run reset brings every present peripheral back
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(periph_enable, 48'h0);
    chk(periph_reg_block, ~48'h0);
    regs = '{16'h0000, 16'h0000, 16'h0000};
    exp_en = P;
    @(posedge clk);
    #1 chk(periph_enable, exp_en);
    check_all;
    wr(4'h3, 16'h1234);
    wr(4'hc, 16'hffff);
    check_all;
    repeat (8)
    begin
      for (int a = 0; a < 3; a++)
        wr(4'(a), 16'($random(seed)));
      check_all;
    end
    for (int a = 0; a < 3; a++)
      wr(4'(a), 16'h0000);
    check_all;
    report_and_stop;
  end
endmodule
